// ### dv/bcep_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bcep_chk (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic TXD,
    input wire logic ERASE_DONE,
    input wire logic ERASE_OK,
    input wire logic ERASE_REQ,
    input wire logic SECURITY_ENABLE_BIT,
    input wire logic BOOT_ABORT,
    input wire logic CLOCKED_MODE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    AST_REQ_PULSE: assert property (ERASE_REQ |=> !ERASE_REQ)
        else $error("erase start pulse too long");
    AST_REQ_QUIET: assert property (ERASE_REQ |-> TXD && !BOOT_ABORT)
        else $error("erase started during an answer");
    AST_RES_WAIT: assert property (ERASE_REQ ##1 !ERASE_DONE [*3] |=> TXD)
        else $error("result sent before erase finished");
    AST_SEC_STICKY: assert property (SECURITY_ENABLE_BIT |=> SECURITY_ENABLE_BIT)
        else $error("security bit dropped");
    AST_SEC_CAUSE: assert property ($rose(SECURITY_ENABLE_BIT) |-> $past(ERASE_OK))
        else $error("security bit set without good erase");
    AST_ABORT_STICKY: assert property (BOOT_ABORT |=> BOOT_ABORT)
        else $error("abort released");
    AST_ABORT_SILENT: assert property (BOOT_ABORT |-> TXD && !ERASE_REQ)
        else $error("aborted session still talks");
    AST_MODE_STICKY: assert property (CLOCKED_MODE |=> CLOCKED_MODE)
        else $error("clocked mode dropped");
endmodule // bcep_chk
`default_nettype wire

// ### dv/bcep_host.sv
`timescale 1ns/1ps
`default_nettype none
module bcep_host (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic sclk
);
    int bt = 16;
    int h = 4;
    bit ck = 1'b0;
    logic [7:0] q[$];
    logic [7:0] rb;
    initial begin
        rxd = 1'b1;
        // Clock stands still high between frames
        sclk = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [7:0] b, input logic stp = 1'b1);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        if (ck) begin
            for (int i = 0; i < 8; i++) begin
                rxd = b[i];
                sclk = 1'b0;
                w(h);
                sclk = 1'b1;
                w(h);
            end
        end else begin
            for (int i = 0; i < 10; i++) begin
                rxd = f[i];
                w(bt);
            end
        end
        // Idle a cycle so the next byte never lands in the same step
        rxd = 1'b1;
        w(1);
    endtask
    // Host waits for each answer before its next byte
    task automatic get(output logic [7:0] b);
        if (ck) begin
            w(6);
            for (int i = 0; i < 8; i++) begin
                sclk = 1'b0;
                w(h);
                rb[i] = txd;
                sclk = 1'b1;
                w(h);
            end
            q.push_back(rb);
        end
        for (int k = 0; k < 30000 && q.size() == 0; k++) w(1);
        b = (q.size() > 0) ? q.pop_front() : 8'hxx;
        w(ck ? 4 : 2 * bt);
    endtask
    // Free-running receiver, UART mode only, so no answer is missed
    always begin
        @(negedge txd);
        if (!ck) begin
            repeat (bt / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bt) @(posedge clk);
                rb[i] = txd;
            end
            q.push_back(rb);
        end
    end
endmodule // bcep_host
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    logic CLK;
    logic RST_B;
    logic ERASE_DONE;
    logic ERASE_OK;
    wire RXD;
    wire SCLK;
    wire TXD;
    wire ERASE_REQ;
    wire SECURITY_ENABLE_BIT;
    wire BOOT_ABORT;
    wire CLOCKED_MODE;
    int n_errors = 0;
    int compares = 0;
    int n_req = 0;
    logic [7:0] v;
    bcep_top dut_u (
        .CLK(CLK),
        .RST_B(RST_B),
        .RXD(RXD),
        .SCLK(SCLK),
        .TXD(TXD),
        .ERASE_DONE(ERASE_DONE),
        .ERASE_OK(ERASE_OK),
        .ERASE_REQ(ERASE_REQ),
        .SECURITY_ENABLE_BIT(SECURITY_ENABLE_BIT),
        .BOOT_ABORT(BOOT_ABORT),
        .CLOCKED_MODE(CLOCKED_MODE)
    );
    bcep_host host_u (.clk(CLK), .txd(TXD), .rxd(RXD), .sclk(SCLK));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Eraser answers late so the wait is exercised
    always @(posedge CLK) begin
        if (ERASE_REQ === 1'b1) begin
            n_req++;
            repeat (20) @(posedge CLK);
            #1 ERASE_DONE = 1'b1;
            @(posedge CLK);
            #1 ERASE_DONE = 1'b0;
        end
    end
    task automatic rst();
        RST_B = 1'b0;
        repeat (16) @(posedge CLK);
        #1 RST_B = 1'b1;
        host_u.q.delete();
        host_u.w(4);
    endtask
    task automatic ex(input logic [7:0] e, input logic [7:0] m = 8'hFF);
        host_u.get(v);
        `CHK(v & m, e)
    endtask
    task automatic pw(input logic bad);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 12; i++) begin
            host_u.put(8'hFF);
            s = s + 8'hFF;
        end
        host_u.put(8'h00 - s + {7'h0, bad});
    endtask
    task automatic era(input logic ok, input logic [7:0] r);
        ERASE_OK = ok;
        n_req = 0;
        host_u.put(8'h40);
        ex(8'h40);
        pw(1'b0);
        ex(8'h40);
        host_u.put(8'h54);
        ex(8'h54);
        host_u.w(40);
        ex(r);
        `CHK(n_req, 1)
    endtask
    task automatic s_uart();
        rst();
        host_u.put(8'h86);
        ex(8'h86);
        `CHK(CLOCKED_MODE, 1'b0)
        era(1'b1, 8'h4F);
        `CHK(SECURITY_ENABLE_BIT, 1'b1)
        era(1'b0, 8'h4C);
        `CHK(SECURITY_ENABLE_BIT, 1'b1)
    endtask
    task automatic s_neg();
        host_u.put(8'h23);
        ex(8'h01, 8'h0F);
        host_u.put(8'h77);
        ex(8'h21);
        host_u.put(8'h40);
        ex(8'h40);
        pw(1'b1);
        ex(8'h01, 8'h0F);
        host_u.put(8'h40);
        ex(8'h40);
        pw(1'b0);
        ex(8'h40);
        host_u.put(8'h55);
        ex(8'h01, 8'h0F);
        host_u.put(8'h40, 1'b0);
        ex(8'h08, 8'h0F);
        host_u.put(8'h40);
        ex(8'h40);
    endtask
    task automatic s_clk();
        rst();
        host_u.ck = 1'b1;
        host_u.h = 64;
        host_u.put(8'h30);
        ex(8'h30);
        `CHK(CLOCKED_MODE, 1'b1)
        host_u.h = 4;
        host_u.put(8'h40);
        ex(8'h40);
        pw(1'b1);
        ex(8'h01, 8'h0F);
        host_u.put(8'h99);
        ex(8'h41);
        era(1'b1, 8'h4F);
    endtask
    task automatic s_abort();
        host_u.ck = 1'b0;
        rst();
        host_u.bt = 3;
        host_u.put(8'h86);
        host_u.w(400);
        `CHK(BOOT_ABORT, 1'b1)
        `CHK(host_u.q.size(), 0)
        rst();
        host_u.ck = 1'b1;
        host_u.h = 4;
        host_u.put(8'h31);
        host_u.w(8);
        `CHK(CLOCKED_MODE, 1'b1)
        `CHK(BOOT_ABORT, 1'b1)
        `CHK(TXD, 1'b1)
    endtask
    task automatic close_out();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        // Scenarios need about 18k cycles; allow over three times that
        #600_000;
        n_errors++;
        close_out();
    end
    initial begin
        RST_B = 1'b0;
        ERASE_DONE = 1'b0;
        ERASE_OK = 1'b0;
        s_uart();
        s_neg();
        s_clk();
        s_abort();
        close_out();
    end
endmodule // testbench
bind bcep_top bcep_chk chk_u (
    .CLK(CLK),
    .RST_B(RST_B),
    .TXD(TXD),
    .ERASE_DONE(ERASE_DONE),
    .ERASE_OK(ERASE_OK),
    .ERASE_REQ(ERASE_REQ),
    .SECURITY_ENABLE_BIT(SECURITY_ENABLE_BIT),
    .BOOT_ABORT(BOOT_ABORT),
    .CLOCKED_MODE(CLOCKED_MODE)
);
`default_nettype wire

// ### rtl/bcep_top.v
`include "bcep_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module bcep_top (
    input wire CLK,
    input wire RST_B,
    input wire RXD,
    input wire SCLK,
    output wire TXD,
    input wire ERASE_DONE,
    input wire ERASE_OK,
    output wire ERASE_REQ,
    output wire SECURITY_ENABLE_BIT,
    output wire BOOT_ABORT,
    output wire CLOCKED_MODE
);
    localparam LS_DETECT = 3'd0;
    localparam LS_MEAS = 3'd1;
    localparam LS_SKIP = 3'd2;
    localparam LS_IDLE = 3'd3;
    localparam LS_URX = 3'd4;
    localparam LS_TX = 3'd5;
    localparam LS_DEAD = 3'd6;
    localparam P_MODE = 3'd0;
    localparam P_CMD = 3'd1;
    localparam P_PWD = 3'd2;
    localparam P_CSUM = 3'd3;
    localparam P_EN = 3'd4;
    localparam P_ERASE = 3'd5;
    localparam P_ACK = 3'd6;

    function [7:0] bcep_ack;
        input [7:0] last;
        input [3:0] lo;
        begin
            bcep_ack = {last[7:4], lo};
        end
    endfunction

    reg rxd_s1_ff, rxd_s2_ff, rxd_d_ff, sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
    reg [2:0] lk_st_ff;
    reg mode_ff;
    reg [17:0] tmr_ff;
    reg [17:0] bit_ff;
    reg [3:0] bcnt_ff;
    reg [7:0] sh_ff;
    reg [8:0] txsh_ff;
    reg txd_ff;
    reg vld_ff, err_rx_ff, tx_done_ff;
    reg [7:0] rx_byte_ff;
    reg [2:0] p_st_ff, p_ret_ff;
    reg tx_start_ff;
    reg [7:0] tx_data_ff;
    reg [3:0] pcnt_ff;
    reg [7:0] sum_ff;
    reg err_ff;
    reg [7:0] last_cmd_ff;
    reg erase_req_ff, sec_ff;

    // Two-stage synchronisers; the second stage and its one-cycle delayed copy feed logic
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_d_ff <= 1'b1;
            sclk_s1_ff <= 1'b1;
            sclk_s2_ff <= 1'b1;
            sclk_d_ff <= 1'b1;
        end else begin
            rxd_s1_ff <= RXD;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_d_ff <= rxd_s2_ff;
            sclk_s1_ff <= SCLK;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_d_ff <= sclk_s2_ff;
        end
    end

    wire rxd_fall = rxd_d_ff & ~rxd_s2_ff;
    wire rxd_rise = ~rxd_d_ff & rxd_s2_ff;
    wire sclk_rise = ~sclk_d_ff & sclk_s2_ff;
    wire sclk_fall = sclk_d_ff & ~sclk_s2_ff;
    wire [7:0] sh_in = {rxd_s2_ff, sh_ff[7:1]};
    wire [17:0] half_bit = {1'b0, bit_ff[17:1]};
    wire [17:0] tmr_tgt = (bcnt_ff == 4'h0) ? half_bit : bit_ff;
    wire tmr_end = (tmr_ff == tmr_tgt - 18'h0_0001);
    wire bit_end = (tmr_ff == bit_ff - 18'h0_0001);
    // Timer reads one short of the low time when the rise is seen
    wire [17:0] meas_cnt = tmr_ff + 18'h0_0001;
    wire [17:0] meas_bit = {1'b0, meas_cnt[17:1]};

    // Byte-level link: mode detection, receive and transmit
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            lk_st_ff <= LS_DETECT;
            mode_ff <= 1'b0;
            tmr_ff <= 18'h0_0000;
            bit_ff <= `BCEP_BIT_MIN;
            bcnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            txsh_ff <= 9'h1_FF;
            txd_ff <= 1'b1;
            vld_ff <= 1'b0;
            err_rx_ff <= 1'b0;
            tx_done_ff <= 1'b0;
            rx_byte_ff <= 8'h00;
        end else begin
            vld_ff <= 1'b0;
            err_rx_ff <= 1'b0;
            tx_done_ff <= 1'b0;
            case (lk_st_ff)
                LS_DETECT: begin
                    if (sclk_rise) begin
                        mode_ff <= 1'b1;
                        sh_ff <= sh_in;
                        bcnt_ff <= 4'h1;
                        lk_st_ff <= LS_IDLE;
                    end else if (rxd_fall) begin
                        tmr_ff <= 18'h0_0000;
                        lk_st_ff <= LS_MEAS;
                    end
                end
                LS_MEAS: begin
                    // A slow host clock edge marks clocked mode
                    if (sclk_rise) begin
                        mode_ff <= 1'b1;
                        sh_ff <= sh_in;
                        bcnt_ff <= 4'h1;
                        lk_st_ff <= LS_IDLE;
                    end else if (rxd_rise) begin
                        if (meas_bit < `BCEP_BIT_MIN || meas_bit > `BCEP_BIT_MAX) begin
                            lk_st_ff <= LS_DEAD;
                        end else begin
                            bit_ff <= meas_bit;
                            tmr_ff <= 18'h0_0000;
                            bcnt_ff <= 4'h0;
                            lk_st_ff <= LS_SKIP;
                        end
                    end else if (tmr_ff == `BCEP_MEAS_SAT) begin
                        lk_st_ff <= LS_DEAD;
                    end else begin
                        tmr_ff <= tmr_ff + 18'h0_0001;
                    end
                end
                LS_SKIP: begin
                    // Start and bit 0 give two bit times low; rest of byte is skipped
                    if (bit_end) begin
                        tmr_ff <= 18'h0_0000;
                        bcnt_ff <= bcnt_ff + 4'h1;
                        if (bcnt_ff == `BCEP_SKIP_LAST) begin
                            rx_byte_ff <= `BCEP_MODE_UART;
                            vld_ff <= 1'b1;
                            bcnt_ff <= 4'h0;
                            lk_st_ff <= LS_IDLE;
                        end
                    end else begin
                        tmr_ff <= tmr_ff + 18'h0_0001;
                    end
                end
                LS_IDLE: begin
                    if (tx_start_ff) begin
                        bcnt_ff <= 4'h0;
                        tmr_ff <= 18'h0_0000;
                        lk_st_ff <= LS_TX;
                        if (mode_ff) begin
                            txd_ff <= tx_data_ff[0];
                            txsh_ff <= {2'b11, tx_data_ff[7:1]};
                        end else begin
                            txd_ff <= 1'b0;
                            txsh_ff <= {1'b1, tx_data_ff};
                        end
                    end else if (mode_ff) begin
                        if (sclk_rise) begin
                            sh_ff <= sh_in;
                            bcnt_ff <= bcnt_ff + 4'h1;
                            if (bcnt_ff == 4'h7) begin
                                rx_byte_ff <= sh_in;
                                vld_ff <= 1'b1;
                                bcnt_ff <= 4'h0;
                            end
                        end
                    end else if (rxd_fall) begin
                        tmr_ff <= 18'h0_0000;
                        bcnt_ff <= 4'h0;
                        lk_st_ff <= LS_URX;
                    end
                end
                LS_URX: begin
                    if (tmr_end) begin
                        tmr_ff <= 18'h0_0000;
                        bcnt_ff <= bcnt_ff + 4'h1;
                        if (bcnt_ff == 4'h0) begin
                            // Glitch rather than start bit
                            if (rxd_s2_ff) begin
                                lk_st_ff <= LS_IDLE;
                            end
                        end else if (bcnt_ff == 4'h9) begin
                            rx_byte_ff <= sh_ff;
                            vld_ff <= 1'b1;
                            // Framing check exists in this mode only
                            err_rx_ff <= ~rxd_s2_ff;
                            bcnt_ff <= 4'h0;
                            lk_st_ff <= LS_IDLE;
                        end else begin
                            sh_ff <= sh_in;
                        end
                    end else begin
                        tmr_ff <= tmr_ff + 18'h0_0001;
                    end
                end
                LS_TX: begin
                    if (mode_ff) begin
                        if (sclk_rise) begin
                            bcnt_ff <= bcnt_ff + 4'h1;
                            if (bcnt_ff == 4'h7) begin
                                txd_ff <= 1'b1;
                                tx_done_ff <= 1'b1;
                                bcnt_ff <= 4'h0;
                                lk_st_ff <= LS_IDLE;
                            end
                        end else if (sclk_fall && bcnt_ff != 4'h0) begin
                            txd_ff <= txsh_ff[0];
                            txsh_ff <= {1'b1, txsh_ff[8:1]};
                        end
                    end else if (bit_end) begin
                        tmr_ff <= 18'h0_0000;
                        bcnt_ff <= bcnt_ff + 4'h1;
                        if (bcnt_ff == 4'h9) begin
                            tx_done_ff <= 1'b1;
                            bcnt_ff <= 4'h0;
                            lk_st_ff <= LS_IDLE;
                        end else begin
                            txd_ff <= txsh_ff[0];
                            txsh_ff <= {1'b1, txsh_ff[8:1]};
                        end
                    end else begin
                        tmr_ff <= tmr_ff + 18'h0_0001;
                    end
                end
                default: begin
                    txd_ff <= 1'b1;
                end
            endcase
        end
    end

    wire rx_bad = err_rx_ff | err_ff;

    // Command sequence; the link is always idle when a byte arrives
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            p_st_ff <= P_MODE;
            p_ret_ff <= P_CMD;
            tx_start_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            pcnt_ff <= 4'h0;
            sum_ff <= 8'h00;
            err_ff <= 1'b0;
            last_cmd_ff <= `BCEP_LAST_CMD_RST;
            erase_req_ff <= 1'b0;
            sec_ff <= 1'b0;
        end else begin
            tx_start_ff <= 1'b0;
            erase_req_ff <= 1'b0;
            case (p_st_ff)
                P_MODE: begin
                    if (vld_ff) begin
                        if (mode_ff && rx_byte_ff != `BCEP_MODE_CLKD) begin
                            p_st_ff <= P_ERASE;
                            p_ret_ff <= P_ERASE;
                        end else begin
                            tx_data_ff <= rx_byte_ff;
                            tx_start_ff <= 1'b1;
                            p_ret_ff <= P_CMD;
                            p_st_ff <= P_ACK;
                        end
                    end
                end
                P_CMD: begin
                    if (vld_ff) begin
                        err_ff <= 1'b0;
                        sum_ff <= 8'h00;
                        pcnt_ff <= 4'h0;
                        last_cmd_ff <= rx_byte_ff;
                        tx_start_ff <= 1'b1;
                        p_st_ff <= P_ACK;
                        p_ret_ff <= P_CMD;
                        if (err_rx_ff) begin
                            tx_data_ff <= bcep_ack(last_cmd_ff, `BCEP_ERR_LO);
                        end else if (rx_byte_ff == `BCEP_CMD_ERASE) begin
                            tx_data_ff <= `BCEP_CMD_ERASE;
                            p_ret_ff <= P_PWD;
                        end else begin
                            tx_data_ff <= bcep_ack(last_cmd_ff, `BCEP_NAK_LO);
                        end
                    end
                end
                P_PWD: begin
                    if (vld_ff) begin
                        sum_ff <= sum_ff + rx_byte_ff;
                        err_ff <= rx_bad;
                        pcnt_ff <= pcnt_ff + 4'h1;
                        if (pcnt_ff == `BCEP_PWD_LAST) begin
                            p_st_ff <= P_CSUM;
                        end
                    end
                end
                P_CSUM, P_EN: begin
                    if (vld_ff) begin
                        tx_start_ff <= 1'b1;
                        p_st_ff <= P_ACK;
                        // Negative answers fall back to command wait
                        p_ret_ff <= P_CMD;
                        if (rx_bad) begin
                            tx_data_ff <= bcep_ack(last_cmd_ff, `BCEP_ERR_LO);
                        end else if (p_st_ff == P_CSUM && sum_ff + rx_byte_ff == 8'h00) begin
                            // Sum plus checksum wraps to zero
                            tx_data_ff <= `BCEP_CMD_ERASE;
                            p_ret_ff <= P_EN;
                        end else if (p_st_ff == P_EN && rx_byte_ff == `BCEP_CMD_ENABLE) begin
                            tx_data_ff <= `BCEP_CMD_ENABLE;
                            p_ret_ff <= P_ERASE;
                        end else begin
                            tx_data_ff <= bcep_ack(last_cmd_ff, `BCEP_NAK_LO);
                        end
                    end
                end
                P_ERASE: begin
                    // Also the dead end of a refused clocked mode byte
                    if (ERASE_DONE && p_ret_ff != P_ERASE) begin
                        sec_ff <= sec_ff | ERASE_OK;
                        tx_data_ff <= ERASE_OK ? `BCEP_RES_OK : `BCEP_RES_FAIL;
                        tx_start_ff <= 1'b1;
                        p_ret_ff <= P_CMD;
                        p_st_ff <= P_ACK;
                    end
                end
                default: begin
                    if (tx_done_ff) begin
                        p_st_ff <= p_ret_ff;
                        erase_req_ff <= (p_ret_ff == P_ERASE);
                        if (p_ret_ff == P_ERASE) begin
                            p_ret_ff <= P_CMD;
                        end
                    end
                end
            endcase
        end
    end

    assign TXD = txd_ff;
    assign ERASE_REQ = erase_req_ff;
    assign SECURITY_ENABLE_BIT = sec_ff;
    assign BOOT_ABORT = (lk_st_ff == LS_DEAD) | (p_st_ff == P_ERASE && p_ret_ff == P_ERASE);
    assign CLOCKED_MODE = mode_ff;
endmodule // bcep_top
`default_nettype wire

// ### shared/bcep_consts.vh
`ifndef BCEP_CONSTS_VH
`define BCEP_CONSTS_VH
// Mode-select codes, echoed back unchanged
`define BCEP_MODE_UART 8'h86
`define BCEP_MODE_CLKD 8'h30
// Command codes and result codes
`define BCEP_CMD_ERASE 8'h40
`define BCEP_CMD_ENABLE 8'h54
`define BCEP_RES_OK 8'h4F
`define BCEP_RES_FAIL 8'h4C
// Low nibbles of negative and error answers
`define BCEP_NAK_LO 4'h1
`define BCEP_ERR_LO 4'h8
// Password or dummy field length minus one
`define BCEP_PWD_LAST 4'hB
// Reset value of the remembered command
`define BCEP_LAST_CMD_RST 8'h00
// Settable bit time range in CLK cycles
`define BCEP_BIT_MIN 18'h0_0008
`define BCEP_BIT_MAX 18'h0_FFFF
`define BCEP_MEAS_SAT 18'h3_FFFF
// Bit times skipped after measuring the first byte, minus one
`define BCEP_SKIP_LAST 4'h7
`endif
